// [hdl/dim_regs.vh]
`ifndef DIM_REGS_VH
`define DIM_REGS_VH
`define DIM_ADDR_FILT  8'h01
`define DIM_ADDR_INPUT 8'h02
`define DIM_FILT_RST   8'h00
`define DIM_INPUT_RST  8'h00
`define DIM_MODE_LSB   2
`define DIM_MODE_MSB   5
`define DIM_FACT_LSB   6
`define DIM_FACT_MSB   7
`define DIM_BIT_ILV    6
`define DIM_BIT_REAL   5
`define DIM_Q15_SHIFT  15
`endif

// [hdl/dim_halfband.v]
`timescale 1ns/100ps
module dim_halfband #(
    parameter W     = 16,
    parameter STAGE = 1
) (
    input  wire         ref_clk_i,
    input  wire         srst_i,
    input  wire         in_vld_i,
    input  wire [W-1:0] in_data_i,
    input  wire [3:0]   half_i,
    output reg          out_vld_o,
    output reg  [W-1:0] out_data_o
);
    localparam NC = (STAGE == 1) ? 14 : (STAGE == 2) ? 6 : 4;
    localparam SH = (STAGE == 1) ? 15 : (STAGE == 2) ? 12 : 13;
    localparam NH = 2 * NC;
    localparam AW = W + 22;
    localparam signed [AW-1:0] MAXV = (1 <<< (W - 1)) - 1;
    localparam signed [AW-1:0] MINV = -(1 <<< (W - 1));

    // Nonzero odd-phase taps, outermost first; zero taps are skipped
    function signed [15:0] coef;
        input integer k;
        begin
            coef = 16'sh0000;
            case (STAGE)
            1: case (k)
                0: coef = -16'sh0004;  1: coef = 16'sh000D;
                2: coef = -16'sh0022;  3: coef = 16'sh0048;
                4: coef = -16'sh008A;  5: coef = 16'sh00F5;
                6: coef = -16'sh0198;  7: coef = 16'sh028A;
                8: coef = -16'sh03EB;  9: coef = 16'sh05F1;
                10: coef = -16'sh090B; 11: coef = 16'sh0E57;
                12: coef = -16'sh19F2; 13: coef = 16'sh5113;
                default: coef = 16'sh0000;
            endcase
            2: case (k)
                0: coef = -16'sh0002; 1: coef = 16'sh0011;
                2: coef = -16'sh004B; 3: coef = 16'sh00EE;
                4: coef = -16'sh0294; 5: coef = 16'sh09E2;
                default: coef = 16'sh0000;
            endcase
            default: case (k)
                0: coef = -16'sh0027; 1: coef = 16'sh0111;
                2: coef = -16'sh044E; 3: coef = 16'sh1364;
                default: coef = 16'sh0000;
            endcase
            endcase
        end
    endfunction

    reg  signed [W-1:0]  hist_ff [0:NH-2];
    wire signed [W-1:0]  win [0:NH-1];
    reg  signed [AW-1:0] acc;
    reg  signed [AW-1:0] sh;
    reg         [W-1:0]  odd_ff;
    reg         [3:0]    cd_ff;
    integer j;

    assign win[0] = in_data_i;
    genvar g;
    generate
        for (g = 1; g < NH; g = g + 1) begin : g_win
            assign win[g] = hist_ff[g-1];
        end
    endgenerate

    // Symmetric pairs folded before the multiply; center tap is a pure delay
    always @* begin
        acc = {AW{1'b0}};
        for (j = 0; j < NC; j = j + 1) begin
            acc = acc + (win[j] + win[NH-1-j]) * coef(j);
        end
        sh = acc >>> SH;
    end

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            for (j = 0; j < NH - 1; j = j + 1) begin
                hist_ff[j] <= {W{1'b0}};
            end
            odd_ff     <= {W{1'b0}};
            cd_ff      <= 4'h0;
            out_vld_o  <= 1'b0;
            out_data_o <= {W{1'b0}};
        end else begin
            out_vld_o <= 1'b0;
            if (in_vld_i) begin
                hist_ff[0] <= in_data_i;
                for (j = 1; j < NH - 1; j = j + 1) begin
                    hist_ff[j] <= hist_ff[j-1];
                end
                out_data_o <= win[NC];
                out_vld_o  <= 1'b1;
                cd_ff      <= half_i;
                if (sh > MAXV) begin
                    odd_ff <= MAXV[W-1:0];
                end else if (sh < MINV) begin
                    odd_ff <= MINV[W-1:0];
                end else begin
                    odd_ff <= sh[W-1:0];
                end
            end else if (cd_ff == 4'h1) begin
                out_data_o <= odd_ff;
                out_vld_o  <= 1'b1;
                cd_ff      <= 4'h0;
            end else if (cd_ff != 4'h0) begin
                cd_ff <= cd_ff - 4'h1;
            end
        end
    end
endmodule

// [hdl/dim_mixer.v]
`timescale 1ns/100ps
module dim_mixer #(
    parameter W = 16
) (
    input  wire         ref_clk_i,
    input  wire         srst_i,
    input  wire         en_i,
    input  wire [3:0]   step_i,
    input  wire         phase_clr_i,
    input  wire [W-1:0] i_i,
    input  wire [W-1:0] q_i,
    output reg  [W-1:0] i_o,
    output reg  [W-1:0] q_o
);
    localparam AW = W + 18;
    localparam signed [AW-1:0] MAXV = (1 <<< (W - 1)) - 1;
    localparam signed [AW-1:0] MINV = -(1 <<< (W - 1));

    // Cosine of k/16 of a turn; 1.0 is held as the largest Q15 value
    function signed [16:0] cos16;
        input [3:0] k;
        begin
            case (k)
                4'h0, 4'h8: cos16 = 17'sh07FFF;
                4'h1, 4'h7, 4'h9, 4'hF: cos16 = 17'sh0764A;
                4'h2, 4'h6, 4'hA, 4'hE: cos16 = 17'sh05A82;
                4'h3, 4'h5, 4'hB, 4'hD: cos16 = 17'sh030FC;
                default: cos16 = 17'sh00000;
            endcase
            if ((k > 4'h4) && (k < 4'hC)) begin
                cos16 = -cos16;
            end
        end
    endfunction

    function [W-1:0] sat;
        input signed [AW-1:0] v;
        begin
            if (v > MAXV) begin
                sat = MAXV[W-1:0];
            end else if (v < MINV) begin
                sat = MINV[W-1:0];
            end else begin
                sat = v[W-1:0];
            end
        end
    endfunction

    reg  [3:0]           phase_ff;
    wire [3:0]           sin_idx = phase_ff - 4'h4;
    wire signed [16:0]   cv      = cos16(phase_ff);
    wire signed [16:0]   sv      = cos16(sin_idx);
    wire signed [W-1:0]  si      = i_i;
    wire signed [W-1:0]  sq      = q_i;
    wire signed [AW-1:0] ip      = (si * cv - sq * sv) >>> 15;
    wire signed [AW-1:0] qp      = (sq * cv + si * sv) >>> 15;

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            phase_ff <= 4'h0;
            i_o      <= {W{1'b0}};
            q_o      <= {W{1'b0}};
        end else begin
            phase_ff <= phase_clr_i ? 4'h0 : phase_ff + step_i;
            if (en_i) begin
                i_o <= sat(ip);
                q_o <= sat(qp);
            end else begin
                i_o <= i_i;
                q_o <= q_i;
            end
        end
    end
endmodule

// [hdl/dim_interp_mod.v]
`timescale 1ns/100ps
`include "dim_regs.vh"
module dim_interp_mod #(
    parameter W = 16
) (
    input  wire         ref_clk_i,
    input  wire         srst_i,
    input  wire         reg_wr_i,
    input  wire [7:0]   reg_addr_i,
    input  wire [7:0]   reg_wdata_i,
    output reg  [7:0]   reg_rdata_o,
    input  wire [W-1:0] port1_data_i,
    input  wire [W-1:0] port2_data_i,
    output wire         word_taken_o,
    output wire [W-1:0] dac_i_o,
    output wire [W-1:0] dac_q_o
);
    localparam [W-1:0] MAXW = {1'b0, {(W-1){1'b1}}};

    // Negating the most negative word would wrap, so it clips instead
    function [W-1:0] neg_sat;
        input [W-1:0] v;
        begin
            if (v == {1'b1, {(W-1){1'b0}}}) begin
                neg_sat = MAXW;
            end else begin
                neg_sat = ~v + {{(W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    reg [7:0] filt_cfg_ff;
    reg [7:0] in_cfg_ff;
    reg       restart_ff;

    // Configuration registers; a write to either mapped register realigns the word schedule
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            filt_cfg_ff <= `DIM_FILT_RST;
            in_cfg_ff   <= `DIM_INPUT_RST;
            restart_ff  <= 1'b1;
            reg_rdata_o <= 8'h00;
        end else begin
            restart_ff <= 1'b0;
            if (reg_wr_i && (reg_addr_i == `DIM_ADDR_FILT)) begin
                filt_cfg_ff <= reg_wdata_i;
                restart_ff  <= 1'b1;
            end
            if (reg_wr_i && (reg_addr_i == `DIM_ADDR_INPUT)) begin
                in_cfg_ff  <= reg_wdata_i;
                restart_ff <= 1'b1;
            end
            case (reg_addr_i)
                `DIM_ADDR_FILT:  reg_rdata_o <= filt_cfg_ff;
                `DIM_ADDR_INPUT: reg_rdata_o <= in_cfg_ff;
                default:         reg_rdata_o <= 8'h00;
            endcase
        end
    end

    wire [1:0] fsel   = filt_cfg_ff[`DIM_FACT_MSB:`DIM_FACT_LSB];
    wire [3:0] mode   = filt_cfg_ff[`DIM_MODE_MSB:`DIM_MODE_LSB];
    wire       real_m = in_cfg_ff[`DIM_BIT_REAL];
    // Real mode wins over interleave: every port one word feeds I
    wire       ilv    = in_cfg_ff[`DIM_BIT_ILV] & ~real_m;
    wire       shf    = mode[0] & (fsel != 2'b00) & ~real_m;

    // Interpolation factor and complex-sample period in clocks
    wire [3:0] ifac = 4'h1 << fsel;
    wire [4:0] p0   = {1'b0, ifac} << ilv;
    wire [3:0] half1 = p0[4:1];
    wire [3:0] half2 = {1'b0, p0[4:2]};
    wire [3:0] half3 = {2'b00, p0[4:3]};

    // Pin inputs cross into the sample clock through two flops
    reg [W-1:0] p1_s1_ff;
    reg [W-1:0] p1_s2_ff;
    reg [W-1:0] p2_s1_ff;
    reg [W-1:0] p2_s2_ff;

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            p1_s1_ff <= {W{1'b0}};
            p1_s2_ff <= {W{1'b0}};
            p2_s1_ff <= {W{1'b0}};
            p2_s2_ff <= {W{1'b0}};
        end else begin
            p1_s1_ff <= port1_data_i;
            p1_s2_ff <= p1_s1_ff;
            p2_s1_ff <= port2_data_i;
            p2_s2_ff <= p2_s1_ff;
        end
    end

    reg  [4:0]   cnt_ff;
    reg  [4:0]   nxt_cnt;
    reg          wsel_ff;
    reg          rot_ff;
    reg  [W-1:0] hold_i_ff;
    reg  [W-1:0] cap_i_ff;
    reg  [W-1:0] cap_q_ff;
    reg          cvld_ff;
    wire [3:0]   cmask = ifac - 4'h1;
    wire         take  = ~restart_ff && ((cnt_ff[3:0] & cmask) == 4'h0);
    wire         pair  = ~ilv | wsel_ff;
    wire [W-1:0] raw_i = ilv ? hold_i_ff : p1_s2_ff;
    wire [W-1:0] raw_q = real_m ? {W{1'b0}} : (ilv ? p1_s2_ff : p2_s2_ff);

    assign word_taken_o = take;

    always @* begin
        nxt_cnt = cnt_ff + 5'h01;
        if (restart_ff || (nxt_cnt >= p0)) begin
            nxt_cnt = 5'h00;
        end
    end

    // Word pairing and the alternating sign that pre-shifts the band
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_ff    <= 5'h00;
            wsel_ff   <= 1'b0;
            rot_ff    <= 1'b0;
            hold_i_ff <= {W{1'b0}};
            cap_i_ff  <= {W{1'b0}};
            cap_q_ff  <= {W{1'b0}};
            cvld_ff   <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            cvld_ff <= 1'b0;
            if (restart_ff) begin
                wsel_ff <= 1'b0;
                rot_ff  <= 1'b0;
            end else if (take) begin
                wsel_ff <= ilv & ~wsel_ff;
                if (ilv && !wsel_ff) begin
                    hold_i_ff <= p1_s2_ff;
                end
                if (pair) begin
                    cvld_ff <= 1'b1;
                    rot_ff  <= ~rot_ff;
                    if (shf && rot_ff) begin
                        cap_i_ff <= neg_sat(raw_i);
                        cap_q_ff <= neg_sat(raw_q);
                    end else begin
                        cap_i_ff <= raw_i;
                        cap_q_ff <= raw_q;
                    end
                end
            end
        end
    end

    // Identical filter chains keep I and Q aligned sample for sample
    wire [2*W-1:0] ch_in = {cap_q_ff, cap_i_ff};
    wire [2*W-1:0] s1_d;
    wire [2*W-1:0] s2_d;
    wire [2*W-1:0] s3_d;
    wire [1:0]     s1_v;
    wire [1:0]     s2_v;
    wire [1:0]     s3_v;

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ch
            dim_halfband #(
                .W     (W),
                .STAGE (1)
            ) u_hb1 (
                .ref_clk_i  (ref_clk_i),
                .srst_i     (srst_i),
                .in_vld_i   (cvld_ff),
                .in_data_i  (ch_in[c*W +: W]),
                .half_i     (half1),
                .out_vld_o  (s1_v[c]),
                .out_data_o (s1_d[c*W +: W])
            );
            dim_halfband #(
                .W     (W),
                .STAGE (2)
            ) u_hb2 (
                .ref_clk_i  (ref_clk_i),
                .srst_i     (srst_i),
                .in_vld_i   (s1_v[c]),
                .in_data_i  (s1_d[c*W +: W]),
                .half_i     (half2),
                .out_vld_o  (s2_v[c]),
                .out_data_o (s2_d[c*W +: W])
            );
            dim_halfband #(
                .W     (W),
                .STAGE (3)
            ) u_hb3 (
                .ref_clk_i  (ref_clk_i),
                .srst_i     (srst_i),
                .in_vld_i   (s2_v[c]),
                .in_data_i  (s2_d[c*W +: W]),
                .half_i     (half3),
                .out_vld_o  (s3_v[c]),
                .out_data_o (s3_d[c*W +: W])
            );
        end
    endgenerate

    // Pick the chain depth by factor; the sample is held between updates
    reg            fin_v;
    reg  [2*W-1:0] fin_d;
    reg  [2*W-1:0] fin_ff;

    always @* begin
        case (fsel)
            2'b00: begin
                fin_v = cvld_ff;
                fin_d = ch_in;
            end
            2'b01: begin
                fin_v = s1_v[0];
                fin_d = s1_d;
            end
            2'b10: begin
                fin_v = s2_v[0];
                fin_d = s2_d;
            end
            default: begin
                fin_v = s3_v[0];
                fin_d = s3_d;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            fin_ff <= {2*W{1'b0}};
        end else if (fin_v) begin
            fin_ff <= fin_d;
        end
    end

    // Carrier step in sixteenths of the sample clock: code times 8/factor.
    // Odd codes add half an input zone, undoing the sign pre-shift.
    wire [6:0] step_w = {mode, 3'b000} >> fsel;
    wire [3:0] step   = (real_m || fsel == 2'b00) ? 4'h0 : step_w[3:0];

    dim_mixer #(
        .W (W)
    ) u_mix (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .en_i        (~real_m && (fsel != 2'b00)),
        .step_i      (step),
        .phase_clr_i (restart_ff),
        .i_i         (fin_ff[W-1:0]),
        .q_i         (fin_ff[2*W-1:W]),
        .i_o         (dac_i_o),
        .q_o         (dac_q_o)
    );
endmodule

// [verification/dim_src_model.sv]
`timescale 1ns/100ps
module dim_src_model (
    input  wire         ref_clk_i,
    input  wire         word_taken_i,
    input  wire  [15:0] i_val_i,
    input  wire  [15:0] q_val_i,
    output logic [15:0] port1_o,
    output logic [15:0] port2_o
);
    initial begin
        port1_o = 16'h0000;
        port2_o = 16'h0000;
    end
    // Words move only just after a take, so each stays a full word period
    always @(posedge ref_clk_i) begin
        if (word_taken_i) begin
            port1_o <= #1 i_val_i;
            port2_o <= #1 q_val_i;
        end
    end
endmodule

// [verification/dim_interp_mod_asserts.sv]
`timescale 1ns/100ps
module dim_interp_mod_asserts #(
    parameter W = 16
) (
    input wire         ref_clk_i,
    input wire         srst_i,
    input wire         reg_wr_i,
    input wire [7:0]   reg_addr_i,
    input wire [7:0]   reg_wdata_i,
    input wire [7:0]   reg_rdata_o,
    input wire [W-1:0] port1_data_i,
    input wire [W-1:0] port2_data_i,
    input wire         word_taken_o,
    input wire [W-1:0] dac_i_o,
    input wire [W-1:0] dac_q_o
);
    localparam int CALM = 1000;
    logic [7:0] filt_ff;
    logic [7:0] inp_ff;
    logic [3:0] gap_ff;
    logic       arm_ff;
    logic [9:0] calm_ff;
    logic [7:0] rd_exp;
    logic [3:0] span;
    logic       calm;
    assign rd_exp = (reg_addr_i == 8'h01) ? filt_ff : ((reg_addr_i == 8'h02) ? inp_ff : 8'h00);
    assign span = 4'h1 << filt_ff[7:6];
    assign calm = (calm_ff >= CALM);
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            filt_ff <= 8'h00;
            inp_ff <= 8'h00;
            gap_ff <= 4'h0;
            arm_ff <= 1'b0;
            calm_ff <= 10'h000;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'h01) filt_ff <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 8'h02) inp_ff <= reg_wdata_i;
            gap_ff <= word_taken_o ? 4'h1 : ((gap_ff == 4'hF) ? gap_ff : gap_ff + 4'h1);
            arm_ff <= reg_wr_i ? 1'b0 : (word_taken_o | arm_ff);
            // Any port word change or register write restarts settling, so the filters are flushed first
            if (reg_wr_i || !$stable(port1_data_i) || !$stable(port2_data_i)) calm_ff <= 10'h000;
            else if (!calm) calm_ff <= calm_ff + 10'h001;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_gap_word;
        !word_taken_o ##1 word_taken_o;
    endsequence
    sequence s_map_write;
        reg_wr_i && (reg_addr_i == 8'h01 || reg_addr_i == 8'h02) ##1 !reg_wr_i;
    endsequence
    a_rdata_track: assert property (reg_rdata_o == $past(rd_exp))
        else $error("read data differs from register");
    a_unmapped_zero: assert property (reg_addr_i != 8'h01 && reg_addr_i != 8'h02 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_word_period: assert property (word_taken_o && arm_ff |-> gap_ff == span)
        else $error("word period wrong");
    a_word_late: assert property (arm_ff |-> gap_ff <= span)
        else $error("word take overdue");
    a_restart_gap: assert property (s_map_write |-> s_gap_word)
        else $error("restart after write wrong");
    a_release_gap: assert property ($fell(srst_i) |-> s_gap_word)
        else $error("first take after reset wrong");
    a_reset_zero: assert property ($fell(srst_i) |-> dac_i_o == '0 && dac_q_o == '0 && reg_rdata_o == 8'h00)
        else $error("outputs not cleared by reset");
    a_q_zero_real: assert property (inp_ff[5] && calm |-> dac_q_o == '0)
        else $error("q output active in real mode");
    a_i_pass_1x: assert property (filt_ff[7:6] == 2'b00 && !inp_ff[6] && calm |-> dac_i_o == port1_data_i)
        else $error("i output differs from port one");
    a_q_pass_1x: assert property (filt_ff[7:6] == 2'b00 && inp_ff[6:5] == 2'b00 && calm |-> dac_q_o == port2_data_i)
        else $error("q output differs from port two");
endmodule
bind dim_interp_mod dim_interp_mod_asserts #(.W(W)) u_chk (
    .ref_clk_i   (ref_clk_i),
    .srst_i      (srst_i),
    .reg_wr_i    (reg_wr_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_rdata_o (reg_rdata_o),
    .port1_data_i(port1_data_i),
    .port2_data_i(port2_data_i),
    .word_taken_o(word_taken_o),
    .dac_i_o     (dac_i_o),
    .dac_q_o     (dac_q_o)
);

// [verification/test_dual_interp_modulator.sv]
`timescale 1ns/100ps
module test_dual_interp_modulator;
    logic        ref_clk_i    = 1'b0;
    logic        srst_i       = 1'b1;
    logic        reg_wr_i     = 1'b0;
    logic [7:0]  reg_addr_i   = 8'h00;
    logic [7:0]  reg_wdata_i  = 8'h00;
    logic [7:0]  reg_rdata_o;
    logic [15:0] port1_data_i;
    logic [15:0] port2_data_i;
    logic        word_taken_o;
    logic [15:0] dac_i_o;
    logic [15:0] dac_q_o;
    logic [15:0] a_val        = 16'h1000;
    logic [15:0] b_val        = 16'h0800;
    int          failures     = 0;
    int          total_checks = 0;

    dim_interp_mod #(.W(16)) u_dut (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .port1_data_i(port1_data_i),
        .port2_data_i(port2_data_i), .word_taken_o(word_taken_o), .dac_i_o(dac_i_o), .dac_q_o(dac_q_o)
    );
    dim_src_model u_src (
        .ref_clk_i(ref_clk_i), .word_taken_i(word_taken_o), .i_val_i(a_val), .q_val_i(b_val),
        .port1_o(port1_data_i), .port2_o(port2_data_i)
    );

    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Filter gain is a hair under one, so settled values get a small window
    function automatic logic near(input int x, input int y);
        return (x - y <= 12) && (y - x <= 12);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick(1);
        reg_wr_i = 1'b0;
        reg_addr_i = 8'h00;
        tick(2);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr_i = a;
        tick(1);
        chk({8'h00, reg_rdata_o}, exp);
    endtask

    task automatic cfg(input logic [7:0] inp, input logic [7:0] filt);
        wr(8'h02, inp);
        wr(8'h01, filt);
        tick(1100);
    endtask

    task automatic t_regs;
        rd(8'h01, 16'h0000);
        rd(8'h02, 16'h0000);
        wr(8'h01, 8'hC8);
        wr(8'h02, 8'h60);
        wr(8'h03, 8'h5A);
        rd(8'h01, 16'h00C8);
        rd(8'h02, 16'h0060);
        rd(8'h03, 16'h0000);
        $display("test regs done");
    endtask

    task automatic t_rate;
        int n;
        for (int f = 0; f < 4; f++) begin
            wr(8'h01, 8'(f << 6));
            n = 0;
            while (word_taken_o !== 1'b1 && n < 20) begin
                tick(1);
                n++;
            end
            n = 0;
            do begin
                tick(1);
                n++;
            end while (word_taken_o !== 1'b1 && n < 20);
            chk(16'(n), 16'(1 << f));
        end
        $display("test rate done");
    endtask

    task automatic t_real;
        cfg(8'h20, 8'h00);
        chk(dac_i_o, a_val);
        chk(dac_q_o, 16'h0000);
        cfg(8'h20, 8'hE0);
        chk(16'(near($signed(dac_i_o), $signed(a_val))), 16'h0001);
        tick(1);
        chk(16'(near($signed(dac_i_o), $signed(a_val))), 16'h0001);
        chk(dac_q_o, 16'h0000);
        $display("test real done");
    endtask

    task automatic t_dual;
        cfg(8'h00, 8'h00);
        chk(dac_i_o, a_val);
        chk(dac_q_o, b_val);
        cfg(8'h00, 8'h40);
        chk(16'(near($signed(dac_i_o), $signed(a_val))), 16'h0001);
        chk(16'(near($signed(dac_q_o), $signed(b_val))), 16'h0001);
        cfg(8'h40, 8'h40);
        chk(16'(near($signed(dac_q_o), $signed(a_val))), 16'h0001);
        cfg(8'h60, 8'h40);
        chk(dac_q_o, 16'h0000);
        $display("test dual done");
    endtask

    task automatic t_mix(input logic [7:0] f, input int c, input int s, output int d);
        int i0, q0, i1, q1;
        cfg(8'h00, f);
        i0 = $signed(dac_i_o);
        q0 = $signed(dac_q_o);
        tick(1);
        i1 = $signed(dac_i_o);
        q1 = $signed(dac_q_o);
        chk(16'(near((i0 * i0 + q0 * q0) >>> 16, 320)), 16'h0001);
        if (near(i1, (c * i0 - s * q0) >>> 15) && near(q1, (s * i0 + c * q0) >>> 15)) d = 1;
        else if (near(i1, (c * i0 + s * q0) >>> 15) && near(q1, (c * q0 - s * i0) >>> 15)) d = 2;
        else d = 0;
    endtask

    task automatic t_carriers;
        logic [7:0] pc [4] = '{8'h88, 8'hD0, 8'hC8, 8'hD8};
        logic [7:0] nc [4] = '{8'h98, 8'hF0, 8'hF8, 8'hE8};
        int         cc [4] = '{0, 0, 23170, -23170};
        int         sc [4] = '{32768, 32768, 23170, 23170};
        logic [7:0] hc [3] = '{8'h48, 8'h90, 8'hE0};
        int         dp;
        int         dn;
        int         d0;
        for (int k = 0; k < 4; k++) begin
            t_mix(pc[k], cc[k], sc[k], dp);
            t_mix(nc[k], cc[k], sc[k], dn);
            if (k == 0) d0 = dp;
            chk(16'(dp + dn), 16'h0003);
            chk(16'(dp), 16'(d0));
        end
        for (int k = 0; k < 3; k++) begin
            t_mix(hc[k], -32768, 0, dp);
            chk(16'(dp), 16'h0001);
        end
        $display("test carriers done");
    endtask

    task automatic t_reset;
        srst_i = 1'b1;
        tick(2);
        srst_i = 1'b0;
        rd(8'h01, 16'h0000);
        $display("test reset done");
    endtask

    initial begin
        tick(2);
        srst_i = 1'b0;
        t_regs;
        t_rate;
        t_real;
        t_dual;
        t_carriers;
        t_reset;
        test_done;
    end

    initial begin
        #1000000;
        failures++;
        test_done;
    end
endmodule
